/* logic/reset_and_system_integrity.v */
// reset sequencer and system integrity supervisor with an apb register port
// assumes pclk is the cpu clock; pin, detector and option levels are asynchronous
//
// Functional notes
// (R1) three sources; pin held low in delay
// (R2) stabilisation delay of 256 or 4096 cycles
// (R3) two-cycle vector fetch from top bytes
// (R4) reset pin low sensed without a clock
// (R5) watchdog underflow drives pin minimum pulse width
// (R6) undervoltage holds static reset, pin low
// (R7) undervoltage enabled by option; warning needs it
// (R8) warning flag read-only, real-time comparator value
// (R9) warning interrupt on every flag change
// (R10) warning enable bit 6; pending cleared on entry
// (R11) no warning interrupt before delay ends
// (R12) enabling while flag set interrupts at once
// (R13) clock loss selects backup, recovery switches back
// (R14) backup selection sets flag, interrupts if enabled
// (R15) wait mode unchanged; both interrupts wake
// (R16) halt freezes register, disables clock guard
// (R17) warning detector and wake active in halt
// (R18) clock interrupt wakes active-halt, not halt
// (R19) interrupt only when flag and enable set
// (R20) bit 7 selects register page
// (R21) page-0 bit layout, reset 000x 000x
// (R22) main oscillator kept running through reset
// (R23) watchdog flag: set by dog, cleared otherwise; an external pin reset leaves it unchanged
// (R24) undervoltage flag cleared only by software
// (R25) backup flag read-cleared after recovery
// (R26) releases synchronised; delay restarts on reassert
// (R27) reserved bit 3 reads zero
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`include "rsi_defs.vh"

module reset_and_system_integrity (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        rst_pin_in,
    output reg         rst_pin_out,
    output reg         rst_pin_oe_n,
    input  wire        undervolt_low,
    input  wire        supply_warn_raw,
    input  wire        undervolt_opt_en,
    input  wire        long_delay_opt,
    input  wire        main_clk_lost,
    input  wire        dog_underflow,
    input  wire        freq_multiplier_on,
    input  wire        wait_mode,
    input  wire        halt_mode,
    input  wire        active_halt_mode,
    input  wire        supply_warn_isr_ack,
    output reg         cpu_reset_n,
    output reg         vector_fetch,
    output reg  [15:0] vector_addr,
    output reg         osc_keep_on,
    output reg         backup_clk_sel,
    output reg         clock_guard_en,
    output reg         supply_warn_irq,
    output reg         clock_fail_irq,
    output reg         wake_req
);
    localparam [1:0] ST_ACTIVE = 2'd0;
    localparam [1:0] ST_DELAY  = 2'd1;
    localparam [1:0] ST_FETCH  = 2'd2;
    localparam [1:0] ST_RUN    = 2'd3;

    localparam integer DOG_CYC_I = (`RSI_DOG_PULSE_NS + `RSI_CLK_PERIOD_NS - 1) / `RSI_CLK_PERIOD_NS;
    localparam [7:0]   DOG_CYC   = DOG_CYC_I[7:0];

    reg  [1:0]  state_q;
    reg  [12:0] delay_cnt_q;
    reg         fetch_cnt_q;
    reg  [7:0]  dog_cnt_q;
    reg         drive_q;
    reg         page_q;
    reg         warn_en_q;
    reg         cfail_en_q;
    reg         backup_q;
    reg         dog_flag_q;
    reg         uv_flag_q;
    reg         warn_prev_q;
    reg         warn_pend_q;
    reg         run_q;
    reg         pin_mask_q;

    wire [4:0]  lvl_s;
    wire        ext_rel_s;
    wire        uv_low_s;
    wire        warn_raw_s;
    wire        uv_en_s;
    wire        long_s;
    wire        clk_lost_s;
    wire        ext_rst_n;
    wire        uv_hold;
    wire        warn_flag;
    wire        src_active;
    wire        guard_on;
    wire        acc;
    wire        hit;
    wire        wr_done;
    wire        rd_done;
    wire [7:0]  ctrl_rd;
    wire        sel_backup;
    wire        cfail_pend;

    // pin low resets the release path at once; masked while we drive it ourselves
    // and one cycle past the release, so our own low cannot restart the sequence
    assign ext_rst_n = presetn & (rst_pin_in | drive_q | ~rst_pin_oe_n | pin_mask_q);  // [R4]

    sync_two_flop #(
        .W (1)
    ) u_ext_sync (
        .clk   (pclk),
        .rst_n (ext_rst_n),
        .d     (1'b1),
        .q     (ext_rel_s)
    );  // [R26]

    sync_two_flop #(
        .W (5)
    ) u_lvl_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     ({undervolt_low, supply_warn_raw, undervolt_opt_en, long_delay_opt, main_clk_lost}),
        .q     (lvl_s)
    );  // [R26]

    assign uv_low_s   = lvl_s[4];
    assign warn_raw_s = lvl_s[3];
    assign uv_en_s    = lvl_s[2];
    assign long_s     = lvl_s[1];
    assign clk_lost_s = lvl_s[0];

    assign uv_hold    = uv_low_s & uv_en_s;  // [R7]
    assign warn_flag  = warn_raw_s & uv_en_s;  // [R7] [R8]
    assign src_active = ~ext_rel_s | uv_hold | dog_underflow | (dog_cnt_q != 8'h00);  // [R1]

    // clock guard only works with the multiplier on and is off through halt
    assign guard_on   = freq_multiplier_on & ~halt_mode;  // [R16]
    assign sel_backup = guard_on & clk_lost_s;  // [R13]

    // apb: access phase waits one cycle, answer registered
    assign acc     = psel & penable;
    assign hit     = (paddr[`RSI_ADDR_W-1:0] == `RSI_CTRL_OFF) && (paddr[31:`RSI_ADDR_W] == 20'h00000);
    assign wr_done = acc & pready & pwrite & hit & ~pslverr;
    assign rd_done = acc & pready & ~pwrite & hit & ~pslverr;

    // reserved bit reads as zero
    assign ctrl_rd = page_q ? 8'h80 :
                     {page_q, warn_en_q, warn_flag, uv_flag_q, 1'b0,
                      cfail_en_q, backup_q, dog_flag_q};  // [R20] [R21] [R27]

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            if (acc && !pready) begin
                pready  <= 1'b1;
                pslverr <= ~hit;
                prdata  <= (hit && !pwrite) ? {24'h000000, ctrl_rd} : 32'h00000000;
            end else begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // reset sequence
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q     <= ST_ACTIVE;
            delay_cnt_q <= 13'h0000;
            fetch_cnt_q <= 1'b0;
            dog_cnt_q   <= 8'h00;
            drive_q     <= 1'b1;
        end else begin
            if (dog_underflow) begin
                dog_cnt_q <= DOG_CYC;  // [R5]
            end else if (dog_cnt_q != 8'h00) begin
                dog_cnt_q <= dog_cnt_q - 8'h01;
            end
            // any live source restarts the whole sequence
            if (src_active) begin
                state_q     <= ST_ACTIVE;  // [R26]
                delay_cnt_q <= long_s ? `RSI_LONG_DELAY : `RSI_SHORT_DELAY;  // [R2]
                // once driving, keep driving through a restart so the pin never blips high
                drive_q     <= uv_hold | dog_underflow | (dog_cnt_q != 8'h00) | drive_q;  // [R1] [R5] [R6]
            end else begin
                case (state_q)
                    ST_ACTIVE: begin
                        state_q     <= ST_DELAY;
                        delay_cnt_q <= long_s ? `RSI_LONG_DELAY : `RSI_SHORT_DELAY;  // [R2]
                        drive_q     <= 1'b1;  // [R1]
                    end
                    ST_DELAY: begin
                        if (delay_cnt_q == 13'h0001) begin
                            state_q     <= ST_FETCH;
                            fetch_cnt_q <= 1'b0;
                            drive_q     <= 1'b0;
                        end else begin
                            delay_cnt_q <= delay_cnt_q - 13'h0001;  // [R2]
                            drive_q     <= 1'b1;  // [R1]
                        end
                    end
                    ST_FETCH: begin
                        drive_q <= 1'b0;
                        if (fetch_cnt_q == 1'b1) begin
                            state_q <= ST_RUN;  // [R3]
                        end
                        fetch_cnt_q <= 1'b1;
                    end
                    ST_RUN: begin
                        drive_q <= 1'b0;
                    end
                    default: begin
                        state_q <= ST_ACTIVE;
                        drive_q <= 1'b1;
                    end
                endcase
            end
        end
    end

    // the cpu is held in reset directly by the pin, even with pclk stopped
    always @(posedge pclk or negedge ext_rst_n) begin
        if (!ext_rst_n) begin
            cpu_reset_n <= 1'b0;  // [R4]
        end else begin
            cpu_reset_n <= (state_q == ST_RUN) & ~src_active;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_pin_out  <= 1'b0;
            rst_pin_oe_n <= 1'b0;
            vector_fetch <= 1'b0;
            vector_addr  <= `RSI_VEC_LO;
            osc_keep_on  <= 1'b1;
            run_q        <= 1'b0;
            pin_mask_q   <= 1'b1;
        end else begin
            pin_mask_q   <= ~rst_pin_oe_n;  // [R4]
            rst_pin_out  <= 1'b0;
            rst_pin_oe_n <= ~(drive_q | uv_hold | dog_underflow);  // [R1] [R6]
            vector_fetch <= (state_q == ST_FETCH) & ~src_active;  // [R3]
            vector_addr  <= fetch_cnt_q ? `RSI_VEC_HI : `RSI_VEC_LO;  // [R3]
            osc_keep_on  <= 1'b1;  // [R22]
            run_q        <= (state_q == ST_RUN) & ~src_active;
        end
    end

    // reset-source flags survive sequencer resets; presetn, software zero writes and, for the dog flag, undervoltage clear them
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dog_flag_q <= 1'b0;
            uv_flag_q  <= 1'b0;
        end else begin
            if (uv_hold) begin
                uv_flag_q  <= 1'b1;  // [R24]
                dog_flag_q <= 1'b0;  // [R23]
            end else begin
                if (dog_underflow) begin
                    dog_flag_q <= 1'b1;  // [R23]
                end else if (wr_done && !halt_mode && !page_q && !pwdata[`RSI_DOG_FLAG_BIT]) begin
                    dog_flag_q <= 1'b0;  // [R23]
                end
                if (wr_done && !halt_mode && !page_q && !pwdata[`RSI_UV_FLAG_BIT]) begin
                    uv_flag_q <= 1'b0;  // [R24]
                end
            end
        end
    end

    // control bits restart from reset values whenever the sequencer resets the cpu
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_q      <= 1'b0;
            warn_en_q   <= 1'b0;
            cfail_en_q  <= 1'b0;
            backup_q    <= 1'b0;
            warn_prev_q <= 1'b0;
            warn_pend_q <= 1'b0;
        end else begin
            warn_prev_q <= warn_flag;
            if (!run_q) begin
                page_q      <= 1'b0;
                warn_en_q   <= 1'b0;  // [R11]
                cfail_en_q  <= 1'b0;
                backup_q    <= 1'b0;
                warn_pend_q <= 1'b0;  // [R11]
            end else begin
                // register is frozen in halt
                if (wr_done && !halt_mode) begin
                    page_q <= pwdata[`RSI_PAGE_BIT];  // [R20] [R16]
                    if (!page_q) begin
                        warn_en_q  <= pwdata[`RSI_WARN_EN_BIT];  // [R10]
                        cfail_en_q <= pwdata[`RSI_CFAIL_EN_BIT];
                    end
                end
                // set wins over the acknowledge
                if (warn_en_q && (warn_flag != warn_prev_q)) begin
                    warn_pend_q <= 1'b1;  // [R9] [R17]
                end else if (wr_done && !halt_mode && !page_q && pwdata[`RSI_WARN_EN_BIT] &&
                             !warn_en_q && warn_flag) begin
                    warn_pend_q <= 1'b1;  // [R12]
                end else if (supply_warn_isr_ack || !warn_en_q) begin
                    warn_pend_q <= 1'b0;  // [R10]
                end
                // backup flag: set wins over read-clear; forced low without multiplier
                if (!freq_multiplier_on) begin
                    backup_q <= 1'b0;  // [R25]
                end else if (sel_backup) begin
                    backup_q <= 1'b1;  // [R14]
                end else if (rd_done && !halt_mode && !page_q && !clk_lost_s) begin
                    backup_q <= 1'b0;  // [R25]
                end
            end
        end
    end

    assign cfail_pend = cfail_en_q & backup_q & freq_multiplier_on;  // [R14] [R19]

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            backup_clk_sel  <= 1'b0;
            clock_guard_en  <= 1'b0;
            supply_warn_irq <= 1'b0;
            clock_fail_irq  <= 1'b0;
            wake_req        <= 1'b0;
        end else begin
            backup_clk_sel  <= sel_backup;  // [R13]
            clock_guard_en  <= guard_on;  // [R16]
            supply_warn_irq <= warn_pend_q & warn_en_q;  // [R19]
            clock_fail_irq  <= cfail_pend;  // [R19]
            // warning wakes from every low-power mode; clock fault not from full halt
            wake_req <= (warn_pend_q & warn_en_q & (wait_mode | halt_mode | active_halt_mode)) |
                        (cfail_pend & (wait_mode | active_halt_mode) & ~halt_mode);  // [R15] [R17] [R18]
        end
    end
endmodule // reset_and_system_integrity

/* logic/rsi_defs.vh */
// constants for the reset sequencer and system integrity supervisor
// assumes a 100 MHz pclk and a single register word on apb
`ifndef RSI_DEFS_VH
`define RSI_DEFS_VH

// register map, byte address within the slave window
`define RSI_ADDR_W         12
`define RSI_CTRL_OFF       12'h000

// page-0 field positions
`define RSI_PAGE_BIT       7
`define RSI_WARN_EN_BIT    6
`define RSI_WARN_FLAG_BIT  5
`define RSI_UV_FLAG_BIT    4
`define RSI_RSVD_BIT       3
`define RSI_CFAIL_EN_BIT   2
`define RSI_BACKUP_BIT     1
`define RSI_DOG_FLAG_BIT   0
`define RSI_CTRL_RESET     8'h00

// reset sequence timing
`define RSI_SHORT_DELAY    13'd256
`define RSI_LONG_DELAY     13'd4096
`define RSI_FETCH_CYCLES   2
`define RSI_VEC_LO         16'hfffe
`define RSI_VEC_HI         16'hffff

// minimum watchdog output pulse width and clock period, in ns
`define RSI_DOG_PULSE_NS   200
`define RSI_CLK_PERIOD_NS  10

`endif

/* logic/sync_two_flop.v */
// two flip-flop synchroniser for a group of independent levels
// assumes each bit is a quasi-static level; no word coherence is given
module sync_two_flop #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // first stage feeds the second stage only
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;
endmodule // sync_two_flop

/* dv/reset_and_system_integrity_props.sv */
// port-level assertions for the reset sequencer and supervisor
// assumes it is bound into the top module and sees only its ports
module reset_and_system_integrity_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rst_pin_in,
    input wire logic        rst_pin_out,
    input wire logic        rst_pin_oe_n,
    input wire logic        undervolt_low,
    input wire logic        undervolt_opt_en,
    input wire logic        dog_underflow,
    input wire logic        freq_multiplier_on,
    input wire logic        halt_mode,
    input wire logic        cpu_reset_n,
    input wire logic        vector_fetch,
    input wire logic [15:0] vector_addr,
    input wire logic        osc_keep_on,
    input wire logic        clock_guard_en,
    input wire logic        clock_fail_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // cycles the pin has been pulled low; a counter because 20 is past a repetition
    int unsigned drv_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            drv_q <= 0;
        else
            drv_q <= rst_pin_oe_n ? 0 : drv_q + 1;
    end
    apb_answer_a: assert property (psel && penable && !pready |=> pready)
        else $error("no ready one cycle into the access phase");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    unmapped_err_a: assert property (pready |-> pslverr == (paddr != 32'h0))
        else $error("error response does not match the address");
    osc_run_a: assert property (osc_keep_on)
        else $error("oscillator keep-on dropped");
    open_drain_a: assert property (!rst_pin_out)
        else $error("reset pin driven high");
    pin_async_a: assert property (!rst_pin_in |-> !cpu_reset_n)
        else $error("pin low without cpu reset");
    uv_hold_a: assert property ((undervolt_low && undervolt_opt_en)[*4] |-> !rst_pin_oe_n && !cpu_reset_n)
        else $error("undervoltage not holding reset");
    dog_drive_a: assert property (dog_underflow |-> ##[1:2] !rst_pin_oe_n)
        else $error("watchdog did not pull the pin");
    pulse_width_a: assert property ($rose(rst_pin_oe_n) |-> drv_q >= 20)
        else $error("pin released before minimum width");
    fetch_pair_a: assert property ($rose(vector_fetch) |-> vector_addr == 16'hfffe ##1
        vector_fetch && vector_addr == 16'hffff ##1 !vector_fetch)
        else $error("vector fetch not two cycles from the top bytes");
    fetch_first_a: assert property ($rose(cpu_reset_n) |-> $past(vector_fetch))
        else $error("cpu released without a vector fetch");
    halt_guard_a: assert property (halt_mode |=> !clock_guard_en)
        else $error("clock guard active in halt");
    cfail_pll_a: assert property (clock_fail_irq |-> $past(freq_multiplier_on))
        else $error("clock-fail request with multiplier off");
endmodule // reset_and_system_integrity_props

bind reset_and_system_integrity reset_and_system_integrity_props props_u (.*);

/* dv/board_reset_model.sv */
// board side of the reset pin: pull-up, external reset source and the device's drive
// assumes the bench commands ext_pull and feeds pin_level back to the device
module board_reset_model (
    input  wire logic ext_pull,
    input  wire logic rst_pin_out,
    input  wire logic rst_pin_oe_n,
    output wire logic pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // wired-and of the open-drain pullers; the pull-up wins only when nobody pulls
    assign pin_level = !(ext_pull || (!rst_pin_oe_n && !rst_pin_out));
endmodule // board_reset_model

/* dv/reset_and_system_integrity_tb.sv */
// self-checking bench for the reset sequencer and supervisor
// assumes the design and board model are compiled first, pclk at 100 MHz
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; $display("Error at %0t: got %0h expected %0h", $time, (a), (e)); end end
module reset_and_system_integrity_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, lfsr = 32'h372a;
    logic        undervolt_low = 0, supply_warn_raw = 0, undervolt_opt_en = 0, long_delay_opt = 0;
    logic        main_clk_lost = 0, dog_underflow = 0, freq_multiplier_on = 0, wait_mode = 0;
    logic        halt_mode = 0, active_halt_mode = 0, supply_warn_isr_ack = 0, ext_pull = 0;
    wire  [31:0] prdata;
    wire  [15:0] vector_addr;
    wire         pready, pslverr, rst_pin_out, rst_pin_oe_n, pin_lvl, cpu_reset_n, vector_fetch;
    wire         osc_keep_on, backup_clk_sel, clock_guard_en, supply_warn_irq, clock_fail_irq, wake_req;
    int          err_total = 0, num_checks = 0;
    logic [9:0]  expq[$];
    logic [9:0]  e;

    always #5 pclk = ~pclk;

    reset_and_system_integrity dut_u (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .rst_pin_in(pin_lvl), .rst_pin_out, .rst_pin_oe_n, .undervolt_low, .supply_warn_raw,
        .undervolt_opt_en, .long_delay_opt, .main_clk_lost, .dog_underflow, .freq_multiplier_on,
        .wait_mode, .halt_mode, .active_halt_mode, .supply_warn_isr_ack, .cpu_reset_n, .vector_fetch,
        .vector_addr, .osc_keep_on, .backup_clk_sel, .clock_guard_en, .supply_warn_irq,
        .clock_fail_irq, .wake_req
    );
    board_reset_model bm_u (.ext_pull, .rst_pin_out, .rst_pin_oe_n, .pin_level(pin_lvl));

    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task final_report();
        if (err_total == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // expectation is {check data, error, data}; upper write bits are random and must be ignored
    task apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [9:0] x);
        int n;
        lfsr = lfsr_step(lfsr);
        expq.push_back(x);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {20'h0, a};
        pwdata <= {lfsr[31:8], d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            final_report();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wait_on(input int sel, input logic v, input int lim, output int n);
        logic s;
        n = 0;
        forever begin
            s = sel == 0 ? cpu_reset_n : sel == 1 ? supply_warn_irq : sel == 2 ? clock_fail_irq : backup_clk_sel;
            if (s === v)
                break;
            if (n >= lim) begin
                err_total++;
                final_report();
            end
            @(posedge pclk);
            n++;
        end
    endtask

    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            e = expq.pop_front();
            `CHK(pslverr, e[8])
            if (e[9])
                `CHK(prdata, {24'h0, e[7:0]})
        end
    end

    initial begin
        int n;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        wait_on(0, 1'b1, 400, n);
        `CHK(n >= 258 && n <= 266, 1'b1)
        apb(0, 12'h0, 8'h00, 10'h200);
        supply_warn_raw <= 1'b1;
        apb(1, 12'h0, 8'h7f, 10'h000);
        apb(0, 12'h0, 8'h00, 10'h244);
        apb(1, 12'h0, 8'hc4, 10'h000);
        apb(0, 12'h0, 8'h00, 10'h280);
        apb(1, 12'h0, 8'h00, 10'h000);
        apb(0, 12'h4, 8'h00, 10'h300);
        apb(0, 12'h0, 8'h00, 10'h244);
        apb(1, 12'h0, 8'h04, 10'h000);
        undervolt_opt_en <= 1'b1;
        repeat (6) @(posedge pclk);
        `CHK(supply_warn_irq, 1'b0)
        apb(1, 12'h0, 8'h44, 10'h000);
        wait_on(1, 1'b1, 4, n);
        apb(0, 12'h0, 8'h00, 10'h264);
        supply_warn_isr_ack <= 1'b1;
        @(posedge pclk);
        supply_warn_isr_ack <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK(supply_warn_irq, 1'b0)
        supply_warn_raw <= 1'b0;
        wait_on(1, 1'b1, 8, n);
        // watchdog with the long delay: control bits return to reset, dog flag sets
        long_delay_opt <= 1'b1;
        dog_underflow <= 1'b1;
        @(posedge pclk);
        dog_underflow <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK(pin_lvl, 1'b0)
        wait_on(0, 1'b1, 4200, n);
        `CHK(n >= 4094 && n <= 4120, 1'b1)
        long_delay_opt <= 1'b0;
        apb(0, 12'h0, 8'h00, 10'h201);
        undervolt_low <= 1'b1;
        repeat (8) @(posedge pclk);
        `CHK(cpu_reset_n, 1'b0)
        `CHK(pin_lvl, 1'b0)
        undervolt_low <= 1'b0;
        wait_on(0, 1'b1, 400, n);
        apb(0, 12'h0, 8'h00, 10'h210);
        ext_pull <= 1'b1;
        #1;
        `CHK(cpu_reset_n, 1'b0)
        repeat (3) @(posedge pclk);
        ext_pull <= 1'b0;
        wait_on(0, 1'b1, 400, n);
        apb(0, 12'h0, 8'h00, 10'h210);
        apb(1, 12'h0, 8'h00, 10'h000);
        apb(0, 12'h0, 8'h00, 10'h200);
        freq_multiplier_on <= 1'b1;
        apb(1, 12'h0, 8'h04, 10'h000);
        main_clk_lost <= 1'b1;
        wait_on(2, 1'b1, 20, n);
        `CHK(backup_clk_sel, 1'b1)
        apb(0, 12'h0, 8'h00, 10'h206);
        main_clk_lost <= 1'b0;
        wait_on(3, 1'b0, 20, n);
        apb(0, 12'h0, 8'h00, 10'h206);
        apb(0, 12'h0, 8'h00, 10'h204);
        main_clk_lost <= 1'b1;
        wait_on(2, 1'b1, 20, n);
        wait_mode <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK(wake_req, 1'b1)
        wait_mode <= 1'b0;
        halt_mode <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK(clock_guard_en, 1'b0)
        `CHK(wake_req, 1'b0)
        // register frozen in halt: the write is dropped, so the read still shows clock-fail enable and backup flag
        apb(1, 12'h0, 8'h00, 10'h000);
        apb(0, 12'h0, 8'h00, 10'h206);
        halt_mode <= 1'b0;
        active_halt_mode <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK(wake_req, 1'b1)
        active_halt_mode <= 1'b0;
        final_report();
    end
endmodule // reset_and_system_integrity_tb
